// File: ifsb_pkg.sv
package ifsb_pkg;

	// ==========================================================
	// register map (byte addresses on the AHB-Lite slave)
	localparam logic [3:0] ADDR_FLAGS_LOW  = 4'h0;
	localparam logic [3:0] ADDR_FLAGS_HIGH = 4'h4;
	localparam logic [3:0] ADDR_IRQ_EN_LOW  = 4'h8;
	localparam logic [3:0] ADDR_IRQ_EN_HIGH = 4'hc;
	localparam logic [3:0] ADDR_CLR_LOW    = 4'h0; // unused alias guard
	localparam int         ADDR_W          = 4;

	// ==========================================================
	// implemented-bit masks and reset value
	localparam logic [15:0] LOW_IMPL_MASK  = 16'h7fff;
	localparam logic [15:0] HIGH_IMPL_MASK = 16'hff5f;
	localparam logic [15:0] FLAGS_RESET    = 16'h0000;
	localparam logic [15:0] EN_RESET       = 16'h0000;

	// ==========================================================
	// bit positions, first register
	localparam int BIT_ADC_DONE    = 14;
	localparam int BIT_DMA_CH1     = 13;
	localparam int BIT_UART1_TX    = 12;
	localparam int BIT_UART1_RX    = 11;
	localparam int BIT_SPI1_EVENT  = 10;
	localparam int BIT_SPI1_FAULT  = 9;
	localparam int BIT_TIMER3      = 8;
	localparam int BIT_TIMER2      = 7;
	localparam int BIT_OCMP_CH2    = 6;
	localparam int BIT_ICAP_CH2    = 5;
	localparam int BIT_DMA_CH0     = 4;
	localparam int BIT_TIMER1      = 3;
	localparam int BIT_OCMP_CH1    = 2;
	localparam int BIT_ICAP_CH1    = 1;
	localparam int BIT_EXT_IRQ0    = 0;

	// bit positions, second register
	localparam int BIT_UART2_TX    = 15;
	localparam int BIT_UART2_RX    = 14;
	localparam int BIT_EXT_IRQ2    = 13;
	localparam int BIT_TIMER5      = 12;
	localparam int BIT_TIMER4      = 11;
	localparam int BIT_OCMP_CH4    = 10;
	localparam int BIT_OCMP_CH3    = 9;
	localparam int BIT_DMA_CH2     = 8;
	localparam int BIT_ICAP_CH7    = 6;
	localparam int BIT_EXT_IRQ1    = 4;
	localparam int BIT_CHANGE_NTFY = 3;
	localparam int BIT_COMPARATOR  = 2;
	localparam int BIT_I2C1_MASTER = 1;
	localparam int BIT_I2C1_SLAVE  = 0;

	// ==========================================================
	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage : ifsb_pkg

// File: ifsb_flag_bank.sv
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
// Notes on behaviour
// - a flag reads 1 once its source has raised a request.
// - a flag reading 0 means no request from that source is pending.
// - every implemented flag is software readable and writable and is 0 after reset.
// - bit 15 of the low register is unimplemented and reads 0.
// - bits 7 and 5 of the high register are unimplemented and read 0.
// - the low register holds the adc done flag at bit 14.
// - dma channel 1 sits at low bit 13, channel 0 at low bit 4, channel 2 at high bit 8.
// - uart1 tx/rx at low bits 12/11, uart2 tx/rx at high bits 15/14.
// - spi1 event at low bit 10 and spi1 fault at low bit 9.
// - timers 3, 2, 1 at low bits 8, 7, 3; timers 5, 4 at high bits 12, 11.
// - output compare 2, 1 at low bits 6, 2; 4, 3 at high bits 10, 9.
// - input capture 2, 1 at low bits 5, 1; channel 7 at high bit 6.
// - external irq 0 at low bit 0; irq 2, 1 at high bits 13, 4.
// - change notification sits at high bit 3.
// - high bits 2, 1, 0 hold comparator, i2c1 master and i2c1 slave flags.
module ifsb_flag_bank (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// peripheral request pulses/levels, same clock
	input  wire logic        adc_done_req,
	input  wire logic [2:0]  dma_ch_req,
	input  wire logic        uart1_tx_req,
	input  wire logic        uart1_rx_req,
	input  wire logic        uart2_tx_req,
	input  wire logic        uart2_rx_req,
	input  wire logic        spi1_event_req,
	input  wire logic        spi1_fault_req,
	input  wire logic [4:0]  timer_req,
	input  wire logic [3:0]  ocmp_req,
	input  wire logic        icap_ch1_req,
	input  wire logic        icap_ch2_req,
	input  wire logic        icap_ch7_req,
	input  wire logic [2:0]  ext_irq_req,
	input  wire logic        change_notify_req,
	input  wire logic        comparator_req,
	input  wire logic        i2c1_master_event_req,
	input  wire logic        i2c1_slave_event_req,
	// interrupt
	output logic             irq
);

	// ==========================================================
	// request mapping
	logic [15:0] set_low;
	logic [15:0] set_high;

	always_comb begin
		set_low                                = 16'h0000;
		set_low[ifsb_pkg::BIT_ADC_DONE]        = adc_done_req;
		set_low[ifsb_pkg::BIT_DMA_CH1]         = dma_ch_req[1];
		set_low[ifsb_pkg::BIT_DMA_CH0]         = dma_ch_req[0];
		set_low[ifsb_pkg::BIT_UART1_TX]        = uart1_tx_req;
		set_low[ifsb_pkg::BIT_UART1_RX]        = uart1_rx_req;
		set_low[ifsb_pkg::BIT_SPI1_EVENT]      = spi1_event_req;
		set_low[ifsb_pkg::BIT_SPI1_FAULT]      = spi1_fault_req;
		set_low[ifsb_pkg::BIT_TIMER3]          = timer_req[2];
		set_low[ifsb_pkg::BIT_TIMER2]          = timer_req[1];
		set_low[ifsb_pkg::BIT_TIMER1]          = timer_req[0];
		set_low[ifsb_pkg::BIT_OCMP_CH2]        = ocmp_req[1];
		set_low[ifsb_pkg::BIT_OCMP_CH1]        = ocmp_req[0];
		set_low[ifsb_pkg::BIT_ICAP_CH2]        = icap_ch2_req;
		set_low[ifsb_pkg::BIT_ICAP_CH1]        = icap_ch1_req;
		set_low[ifsb_pkg::BIT_EXT_IRQ0]        = ext_irq_req[0];
		set_high                               = 16'h0000;
		set_high[ifsb_pkg::BIT_DMA_CH2]        = dma_ch_req[2];
		set_high[ifsb_pkg::BIT_UART2_TX]       = uart2_tx_req;
		set_high[ifsb_pkg::BIT_UART2_RX]       = uart2_rx_req;
		set_high[ifsb_pkg::BIT_TIMER5]         = timer_req[4];
		set_high[ifsb_pkg::BIT_TIMER4]         = timer_req[3];
		set_high[ifsb_pkg::BIT_OCMP_CH4]       = ocmp_req[3];
		set_high[ifsb_pkg::BIT_OCMP_CH3]       = ocmp_req[2];
		set_high[ifsb_pkg::BIT_ICAP_CH7]       = icap_ch7_req;
		set_high[ifsb_pkg::BIT_EXT_IRQ2]       = ext_irq_req[2];
		set_high[ifsb_pkg::BIT_EXT_IRQ1]       = ext_irq_req[1];
		set_high[ifsb_pkg::BIT_CHANGE_NTFY]    = change_notify_req;
		set_high[ifsb_pkg::BIT_COMPARATOR]     = comparator_req;
		set_high[ifsb_pkg::BIT_I2C1_MASTER]    = i2c1_master_event_req;
		set_high[ifsb_pkg::BIT_I2C1_SLAVE]     = i2c1_slave_event_req;
	end

	// ==========================================================
	// ahb-lite address phase capture
	function automatic logic reg_hit(input logic [ifsb_pkg::ADDR_W-1:0] a, input logic [3:0] offs);
		reg_hit = (a == offs);
	endfunction

	logic                        wr_pend_q;
	logic                        wr_pend_d;
	logic [ifsb_pkg::ADDR_W-1:0] addr_q;
	logic [ifsb_pkg::ADDR_W-1:0] addr_d;
	logic                        rd_pend_q;
	logic                        rd_pend_d;
	logic                        valid_xfer;

	assign valid_xfer = hsel && hready &&
		(htrans == ifsb_pkg::HTRANS_NONSEQ || htrans == ifsb_pkg::HTRANS_SEQ);

	always_comb begin
		wr_pend_d = valid_xfer && hwrite;
		rd_pend_d = valid_xfer && !hwrite;
		addr_d    = valid_xfer ? haddr[ifsb_pkg::ADDR_W-1:0] : addr_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= '0;
		end else begin
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			addr_q    <= addr_d;
		end
	end

	// zero wait states; every access answers okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ==========================================================
	// flag and enable registers
	logic [15:0] flags_low_q;
	logic [15:0] flags_low_d;
	logic [15:0] flags_high_q;
	logic [15:0] flags_high_d;
	logic [15:0] en_low_q;
	logic [15:0] en_low_d;
	logic [15:0] en_high_q;
	logic [15:0] en_high_d;
	logic        wr_low;
	logic        wr_high;

	assign wr_low  = wr_pend_q && reg_hit(addr_q, ifsb_pkg::ADDR_FLAGS_LOW);
	assign wr_high = wr_pend_q && reg_hit(addr_q, ifsb_pkg::ADDR_FLAGS_HIGH);

	// software may write 1 as well as 0; a request in the write cycle still lands
	always_comb begin
		flags_low_d  = (wr_low ? hwdata[15:0] : flags_low_q) | set_low;
		flags_low_d  = flags_low_d & ifsb_pkg::LOW_IMPL_MASK;
		flags_high_d = (wr_high ? hwdata[15:0] : flags_high_q) | set_high;
		flags_high_d = flags_high_d & ifsb_pkg::HIGH_IMPL_MASK;
		en_low_d     = (wr_pend_q && reg_hit(addr_q, ifsb_pkg::ADDR_IRQ_EN_LOW)) ?
			(hwdata[15:0] & ifsb_pkg::LOW_IMPL_MASK) : en_low_q;
		en_high_d    = (wr_pend_q && reg_hit(addr_q, ifsb_pkg::ADDR_IRQ_EN_HIGH)) ?
			(hwdata[15:0] & ifsb_pkg::HIGH_IMPL_MASK) : en_high_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_low_q  <= ifsb_pkg::FLAGS_RESET;
			flags_high_q <= ifsb_pkg::FLAGS_RESET;
			en_low_q     <= ifsb_pkg::EN_RESET;
			en_high_q    <= ifsb_pkg::EN_RESET;
		end else begin
			flags_low_q  <= flags_low_d;
			flags_high_q <= flags_high_d;
			en_low_q     <= en_low_d;
			en_high_q    <= en_high_d;
		end
	end

	// ==========================================================
	// read data, combinational from registers in the data phase
	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_pend_q) begin
			case (addr_q)
				ifsb_pkg::ADDR_FLAGS_LOW:   hrdata[15:0] = flags_low_q;
				ifsb_pkg::ADDR_FLAGS_HIGH:  hrdata[15:0] = flags_high_q;
				ifsb_pkg::ADDR_IRQ_EN_LOW:  hrdata[15:0] = en_low_q;
				ifsb_pkg::ADDR_IRQ_EN_HIGH: hrdata[15:0] = en_high_q;
				default:                    hrdata = 32'h0000_0000;
			endcase
		end
	end

	// level interrupt, released once software clears the flag or its enable bit
	assign irq = |(flags_low_q & en_low_q) || |(flags_high_q & en_high_q);

	// ==========================================================
	// checks
	a_req_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		(|set_low) |=> ((flags_low_q & $past(set_low)) == $past(set_low)))
		else $error("low flag request not latched");
	a_high_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_high && |set_high) |=> ((flags_high_q & $past(set_high)) == $past(set_high)))
		else $error("set lost against clear");
	a_flag_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		(!wr_low && flags_low_q[ifsb_pkg::BIT_ADC_DONE]) |=> flags_low_q[ifsb_pkg::BIT_ADC_DONE])
		else $error("flag dropped without clear");
	a_low_top_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		!flags_low_q[15])
		else $error("unimplemented low bit set");
	a_high_gaps_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		!flags_high_q[7] && !flags_high_q[5])
		else $error("unimplemented high bit set");
	a_clear_takes: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_low && hwdata[15:0] == 16'h0000 && set_low == 16'h0000) |=> flags_low_q == 16'h0000)
		else $error("clear write ignored");
	a_adc_place: assert property (@(posedge hclk) disable iff (!hresetn)
		adc_done_req |=> flags_low_q[14])
		else $error("adc flag misplaced");
	a_i2c_place: assert property (@(posedge hclk) disable iff (!hresetn)
		(i2c1_slave_event_req || comparator_req) |=>
		((flags_high_q[0] || !$past(i2c1_slave_event_req)) && (flags_high_q[2] || !$past(comparator_req))))
		else $error("i2c or comparator flag misplaced");
	a_read_zero_none: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_pend_q && addr_q == ifsb_pkg::ADDR_FLAGS_HIGH) |-> hrdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");

endmodule // ifsb_flag_bank

// File: ifsb_req_model.sv
`timescale 1ns/100ps
// ==========================================================
// peripheral side: src_q[15:0] feeds the low register's flag positions, src_q[31:16] the high one
module ifsb_req_model (
	input  wire logic       hclk,
	output logic            adc_done_req,
	output logic [2:0]      dma_ch_req,
	output logic            uart1_tx_req,
	output logic            uart1_rx_req,
	output logic            uart2_tx_req,
	output logic            uart2_rx_req,
	output logic            spi1_event_req,
	output logic            spi1_fault_req,
	output logic [4:0]      timer_req,
	output logic [3:0]      ocmp_req,
	output logic            icap_ch1_req,
	output logic            icap_ch2_req,
	output logic            icap_ch7_req,
	output logic [2:0]      ext_irq_req,
	output logic            change_notify_req,
	output logic            comparator_req,
	output logic            i2c1_master_event_req,
	output logic            i2c1_slave_event_req
);
	logic [31:0] src_q = 32'h0;

	assign adc_done_req          = src_q[14];
	assign dma_ch_req            = {src_q[24], src_q[13], src_q[4]};
	assign uart1_tx_req          = src_q[12];
	assign uart1_rx_req          = src_q[11];
	assign uart2_tx_req          = src_q[31];
	assign uart2_rx_req          = src_q[30];
	assign spi1_event_req        = src_q[10];
	assign spi1_fault_req        = src_q[9];
	assign timer_req             = {src_q[28], src_q[27], src_q[8], src_q[7], src_q[3]};
	assign ocmp_req              = {src_q[26], src_q[25], src_q[6], src_q[2]};
	assign icap_ch1_req          = src_q[1];
	assign icap_ch2_req          = src_q[5];
	assign icap_ch7_req          = src_q[22];
	assign ext_irq_req           = {src_q[29], src_q[20], src_q[0]};
	assign change_notify_req     = src_q[19];
	assign comparator_req        = src_q[18];
	assign i2c1_master_event_req = src_q[17];
	assign i2c1_slave_event_req  = src_q[16];

	// one-cycle pulse only, so a flag that fails to hold its state is caught on readback
	task automatic fire(input int i);
		@(posedge hclk);
		src_q[i] <= 1'b1;
		@(posedge hclk);
		src_q[i] <= 1'b0;
	endtask
endmodule // ifsb_req_model

// File: interrupt_flag_status_bank_bench.sv
`timescale 1ns/100ps
module interrupt_flag_status_bank_bench;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [2:0]  hsize   = 3'h2;
	logic [31:0] hwdata  = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic [31:0] rd;
	logic [2:0]  dma_ch_req;
	logic [4:0]  timer_req;
	logic [3:0]  ocmp_req;
	logic [2:0]  ext_irq_req;
	logic        adc_done_req, uart1_tx_req, uart1_rx_req, uart2_tx_req, uart2_rx_req, spi1_event_req;
	logic        spi1_fault_req, icap_ch1_req, icap_ch2_req, icap_ch7_req, change_notify_req;
	logic        comparator_req, i2c1_master_event_req, i2c1_slave_event_req;
	int          num_errors = 0;
	int          tests_run  = 0;

	always #4 hclk = ~hclk;

	ifsb_flag_bank dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .adc_done_req(adc_done_req), .dma_ch_req(dma_ch_req),
		.uart1_tx_req(uart1_tx_req), .uart1_rx_req(uart1_rx_req), .uart2_tx_req(uart2_tx_req),
		.uart2_rx_req(uart2_rx_req), .spi1_event_req(spi1_event_req), .spi1_fault_req(spi1_fault_req),
		.timer_req(timer_req), .ocmp_req(ocmp_req), .icap_ch1_req(icap_ch1_req), .icap_ch2_req(icap_ch2_req),
		.icap_ch7_req(icap_ch7_req), .ext_irq_req(ext_irq_req), .change_notify_req(change_notify_req),
		.comparator_req(comparator_req), .i2c1_master_event_req(i2c1_master_event_req),
		.i2c1_slave_event_req(i2c1_slave_event_req), .irq(irq));

	ifsb_req_model req_u (.hclk(hclk), .adc_done_req(adc_done_req), .dma_ch_req(dma_ch_req),
		.uart1_tx_req(uart1_tx_req), .uart1_rx_req(uart1_rx_req), .uart2_tx_req(uart2_tx_req),
		.uart2_rx_req(uart2_rx_req), .spi1_event_req(spi1_event_req), .spi1_fault_req(spi1_fault_req),
		.timer_req(timer_req), .ocmp_req(ocmp_req), .icap_ch1_req(icap_ch1_req), .icap_ch2_req(icap_ch2_req),
		.icap_ch7_req(icap_ch7_req), .ext_irq_req(ext_irq_req), .change_notify_req(change_notify_req),
		.comparator_req(comparator_req), .i2c1_master_event_req(i2c1_master_event_req),
		.i2c1_slave_event_req(i2c1_slave_event_req));

	// ==========================================================
	// checking and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			give_verdict();
		end
	endtask

	task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {28'h0, a};
		hwrite <= wr;
		htrans <= ifsb_pkg::HTRANS_NONSEQ;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		for (int a = 0; a < 16; a += 4) rdchk(4'(a), 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_access();
		for (int a = 0; a < 16; a += 4) ahb(1'b1, 4'(a), 32'hffffffff);
		rdchk(4'h0, 32'h00007fff);
		rdchk(4'h4, 32'h0000ff5f);
		rdchk(4'h8, 32'h00007fff);
		rdchk(4'hc, 32'h0000ff5f);
		ahb(1'b1, 4'h0, 32'h0);
		ahb(1'b1, 4'h4, 32'h0);
		rdchk(4'h0, 32'h0);
		rdchk(4'h4, 32'h0);
		$display("test access done");
	endtask

	// enables are all on here, so irq follows each single flag
	task automatic t_sources();
		logic [31:0] e;
		for (int i = 0; i < 32; i++) begin
			if (i == 15 || i == 21 || i == 23) continue;
			e = 32'h1 << i;
			req_u.fire(i);
			rdchk(4'h0, {16'h0, e[15:0]});
			rdchk(4'h4, {16'h0, e[31:16]});
			chk({31'h0, irq}, 32'h1);
			ahb(1'b1, (i < 16) ? 4'h0 : 4'h4, 32'h0);
			rdchk((i < 16) ? 4'h0 : 4'h4, 32'h0);
			chk({31'h0, irq}, 32'h0);
		end
		$display("test sources done");
	endtask

	task automatic t_irq_mask();
		ahb(1'b1, 4'h8, 32'h0);
		ahb(1'b1, 4'hc, 32'h0);
		req_u.fire(2);
		@(negedge hclk);
		chk({31'h0, irq}, 32'h0);
		ahb(1'b1, 4'h8, 32'h4);
		@(negedge hclk);
		chk({31'h0, irq}, 32'h1);
		ahb(1'b1, 4'h0, 32'h0);
		@(negedge hclk);
		chk({31'h0, irq}, 32'h0);
		$display("test irq mask done");
	endtask

	// request lands in the same data phase that writes 0 to its flag
	task automatic t_set_wins();
		fork
			ahb(1'b1, 4'h0, 32'h0);
			req_u.fire(0);
		join
		rdchk(4'h0, 32'h1);
		ahb(1'b1, 4'h0, 32'h0);
		rdchk(4'h0, 32'h0);
		$display("test set wins done");
	endtask

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_access();
		t_sources();
		t_irq_mask();
		t_set_wins();
		give_verdict();
	end
endmodule // interrupt_flag_status_bank_bench
